// *** hw/sip_ports.sv ***
// segment-address bidirectional port and input-only port behind an apb slave
`default_nettype none
// Function
// [R1] eight-line port, data latches in low byte, upper byte reads zero
// [R2] direction bit clear means input high impedance, set means drive
// [R3] open drain only on lines 6 and 7, not while carrying segment address
// [R4] other open drain bits unimplemented, read zero
// [R5] selection code maps none, two, four or eight segment address lines
// [R6] segment lines switch to address output automatically after reset
// [R7] selection captured from low data bus pins at reset, readable read-only
// [R8] lines not used for segment address stay general purpose
// [R9] lines 4,5 carry CAN receives, lines 6,7 CAN transmits
// [R10] sixteen input-only lines, no output latch, no direction
// [R11] writes to input-only data register are discarded
// [R12] each input-only line feeds one analog converter channel
// [R13] input lines 10 to 15 feed timer direction and count inputs
// [R14] analog taps come straight from the pins
// [R15] enabled CAN transmit replaces latch; receive taken from input latch
// [R16] data register read returns synchronised pin state for input lines
module sip_ports (
  input  wire logic        pclk,                // system clock, 100 MHz
  input  wire logic        presetn,             // async reset, active low
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [31:0] paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error, unmapped address
  input  wire logic [15:0] low_data_bus_pins,   // strap pins sampled after reset
  input  wire logic [7:0]  seg_pin_in,          // segment port pin levels
  output logic      [7:0]  seg_pin_out,         // segment port output values
  output logic      [7:0]  seg_pin_oe,          // segment port output enables
  input  wire logic [7:0]  segment_address,     // a16..a23 from the bus controller
  input  wire logic        can_first_transmit,  // first CAN transmit
  input  wire logic        can_second_transmit, // second CAN transmit
  output logic             can_first_receive,   // first CAN receive
  output logic             can_second_receive,  // second CAN receive
  input  wire logic [15:0] input_pin,           // input-only port pins
  output logic      [15:0] analog_channel,      // converter mux taps
  output logic             timer6_dir_input,    // timer 6 up/down
  output logic             timer5_dir_input,    // timer 5 up/down
  output logic             timer6_count_input,  // timer 6 count
  output logic             timer5_count_input,  // timer 5 count
  output logic             timer4_dir_input,    // timer 4 up/down
  output logic             timer2_dir_input     // timer 2 up/down
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  seg_port_data;
  logic [7:0]  seg_port_direction;
  logic [1:0]  seg_port_open_drain;   // bits 7:6 only
  logic [1:0]  segment_line_select;
  logic        strap_done;
  logic [1:0]  can_module_enable;
  logic [7:0]  seg_in_sync;
  logic [15:0] input_sync;
  logic [15:0] input_pin_sync;
  logic [7:0]  alt_mask;
  logic [7:0]  next_out;
  logic [7:0]  next_oe;
  logic [31:0] next_rdata;
  logic        next_err;
  logic        setup;
  logic        wr_en;
  logic [17:0] addr;

  assign setup = psel & ~penable;
  assign addr  = paddr[17:0];
  assign wr_en = setup & pwrite & ~next_err;

  // true when the address hits one of our word registers
  function automatic logic mapped(input logic [17:0] a, input logic [31:0] full);
    mapped = (full[31:18] == 14'h0000) &&
             (a == sip_pkg::addr_seg_port_open_drain || a == sip_pkg::addr_input_port_data ||
              a == sip_pkg::addr_seg_port_data || a == sip_pkg::addr_seg_port_direction ||
              a == sip_pkg::addr_reset_config_high || a == sip_pkg::addr_extra_periph_ctrl);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the analog taps bypass them
  sip_sync #(.width(8)) u_seg_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (seg_pin_in),
    .q       (seg_in_sync)
  );

  sip_sync #(.width(16)) u_in_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (input_pin),
    .q       (input_sync)
  );

  sip_sync #(.width(16)) u_strap_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (low_data_bus_pins),
    .q       (input_pin_sync)
  );

  sip_seg_decode u_dec (
    .sel  (segment_line_select),
    .mask (alt_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: async reset may only load a constant, so the code is
  // taken once, by the clock, after the strap levels have passed the synchroniser
  logic [1:0] strap_wait;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_wait          <= 2'h0;
      strap_done          <= 1'b0;
      segment_line_select <= sip_pkg::sip_sel_none;
    end else if (!strap_done) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        segment_line_select <= input_pin_sync[sip_pkg::strap_lo +: 2]; // [R7]
        strap_done          <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers, written in the setup cycle (zero wait states)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_port_data       <= sip_pkg::seg_port_reset;
      seg_port_direction  <= sip_pkg::seg_port_reset;
      seg_port_open_drain <= 2'h0;
      can_module_enable   <= 2'h0;
    end else if (wr_en) begin
      case (addr)
        sip_pkg::addr_seg_port_data:       seg_port_data      <= pwdata[7:0];  // [R1]
        sip_pkg::addr_seg_port_direction:  seg_port_direction <= pwdata[7:0];  // [R2]
        sip_pkg::addr_seg_port_open_drain: seg_port_open_drain <= pwdata[sip_pkg::od_hi:sip_pkg::od_lo]; // [R3]
        sip_pkg::addr_extra_periph_ctrl:   can_module_enable  <= pwdata[1:0];
        default:                           ;  // input port data write is discarded [R11]
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and error decode
  always_comb begin
    next_err   = ~mapped(addr, paddr);
    next_rdata = 32'h0000_0000;
    case (addr)
      sip_pkg::addr_seg_port_data: begin
        // input lines read the pin, output lines read the latch [R16]
        next_rdata[7:0] = (seg_in_sync & ~seg_port_direction) | (seg_port_data & seg_port_direction);
      end
      sip_pkg::addr_seg_port_direction:  next_rdata[7:0] = seg_port_direction;
      sip_pkg::addr_seg_port_open_drain: next_rdata[sip_pkg::od_hi:sip_pkg::od_lo] = seg_port_open_drain; // [R4]
      sip_pkg::addr_input_port_data:     next_rdata[15:0] = input_sync;  // [R10]
      sip_pkg::addr_reset_config_high:   next_rdata[sip_pkg::cfg_sel_lo +: 2] = segment_line_select; // [R7]
      sip_pkg::addr_extra_periph_ctrl:   next_rdata[1:0] = can_module_enable;
      default:                           next_rdata = 32'h0000_0000;
    endcase
  end

  // zero wait states: answer registered in the setup cycle, given with pready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & next_err;
      prdata  <= (setup & ~pwrite & ~next_err) ? next_rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, one per line
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_line
      logic tx_en;
      logic tx_val;
      logic od;
      if (g == sip_pkg::line_can_first_tx) begin : g_tx1
        assign tx_en  = can_module_enable[sip_pkg::can_first_en_bit];
        assign tx_val = can_first_transmit;
      end else if (g == sip_pkg::line_can_second_tx) begin : g_tx2
        assign tx_en  = can_module_enable[sip_pkg::can_second_en_bit];
        assign tx_val = can_second_transmit;
      end else begin : g_notx
        assign tx_en  = 1'b0;
        assign tx_val = 1'b0;
      end
      if (g >= sip_pkg::od_lo) begin : g_od
        assign od = seg_port_open_drain[g - sip_pkg::od_lo];
      end else begin : g_pp
        assign od = 1'b0;
      end
      always_comb begin
        if (strap_done && alt_mask[g]) begin
          next_out[g] = segment_address[g];   // [R6] [R5]
          next_oe[g]  = 1'b1;                 // segment lines ignore open drain [R3]
        end else begin
          // [R8] [R9] [R15]
          next_out[g] = tx_en ? tx_val : seg_port_data[g];
          // open drain lets go of the line for a one so the bus pull-up can win
          next_oe[g]  = seg_port_direction[g] & ~(od & next_out[g]); // [R2] [R3]
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_pin_out <= 8'h00;
      seg_pin_oe  <= 8'h00;
    end else begin
      seg_pin_out <= next_out;
      seg_pin_oe  <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternate inputs; CAN receive is gated off while the line is an address line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_first_receive  <= 1'b1;
      can_second_receive <= 1'b1;
      timer6_dir_input   <= 1'b0;
      timer5_dir_input   <= 1'b0;
      timer6_count_input <= 1'b0;
      timer5_count_input <= 1'b0;
      timer4_dir_input   <= 1'b0;
      timer2_dir_input   <= 1'b0;
      analog_channel     <= 16'h0000;
    end else begin
      can_first_receive  <= alt_mask[sip_pkg::line_can_first_rx] | seg_in_sync[sip_pkg::line_can_first_rx];   // [R9] [R15]
      can_second_receive <= alt_mask[sip_pkg::line_can_second_rx] | seg_in_sync[sip_pkg::line_can_second_rx]; // [R9] [R15]
      timer6_dir_input   <= input_sync[10]; // [R13]
      timer5_dir_input   <= input_sync[11]; // [R13]
      timer6_count_input <= input_sync[12]; // [R13]
      timer5_count_input <= input_sync[13]; // [R13]
      timer4_dir_input   <= input_sync[14]; // [R13]
      timer2_dir_input   <= input_sync[15]; // [R13]
      // digital stand-in for the analog tap: raw pin, one register, no synchroniser [R12] [R14]
      analog_channel     <= input_pin;
    end
  end

endmodule
`default_nettype wire

// *** hw/sip_pkg.sv ***
// package: register map, field positions and reset values of the segment and input ports
`default_nettype none
package sip_pkg;
  // printed offsets are not all multiples of four, so they are indices; byte address is four times the index
  localparam logic [15:0] idx_seg_port_open_drain = 16'hf1ca;
  localparam logic [15:0] idx_input_port_data     = 16'hffa2;
  localparam logic [15:0] idx_seg_port_data       = 16'hffc8;
  localparam logic [15:0] idx_seg_port_direction  = 16'hffca;
  localparam logic [15:0] idx_reset_config_high   = 16'hf000;
  localparam logic [15:0] idx_extra_periph_ctrl   = 16'hf002;
  localparam logic [17:0] addr_seg_port_open_drain = {idx_seg_port_open_drain, 2'b00};
  localparam logic [17:0] addr_input_port_data     = {idx_input_port_data, 2'b00};
  localparam logic [17:0] addr_seg_port_data       = {idx_seg_port_data, 2'b00};
  localparam logic [17:0] addr_seg_port_direction  = {idx_seg_port_direction, 2'b00};
  localparam logic [17:0] addr_reset_config_high   = {idx_reset_config_high, 2'b00};
  localparam logic [17:0] addr_extra_periph_ctrl   = {idx_extra_periph_ctrl, 2'b00};
  localparam logic [7:0]  seg_port_reset           = 8'h00;
  localparam logic [7:0]  od_impl_mask             = 8'hc0;
  localparam int          od_lo                    = 6;
  localparam int          od_hi                    = 7;
  localparam int          can_first_en_bit         = 0;
  localparam int          can_second_en_bit        = 1;
  localparam int          line_can_second_rx       = 4;
  localparam int          line_can_first_rx        = 5;
  localparam int          line_can_first_tx        = 6;
  localparam int          line_can_second_tx       = 7;
  localparam int          strap_lo                 = 11;
  localparam int          cfg_sel_lo               = 0;
  typedef enum logic [1:0] {
    sip_sel_4_lines = 2'b00,
    sip_sel_none    = 2'b01,
    sip_sel_8_lines = 2'b10,
    sip_sel_2_lines = 2'b11
  } sip_sel_t;
endpackage
`default_nettype wire

// *** hw/sip_sync.sv ***
// two flip-flop synchroniser for a vector of pin levels
`default_nettype none
module sip_sync #(
  parameter int width = 8
) (
  input  wire logic             pclk,    // system clock
  input  wire logic             presetn, // async reset, active low
  input  wire logic [width-1:0] d,       // asynchronous levels
  output logic      [width-1:0] q        // synchronised levels
);
  logic [width-1:0] meta;
  // meta feeds only q, nothing else looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** hw/sip_seg_decode.sv ***
// decode of the segment line selection code into a per-line alternate enable mask
`default_nettype none
module sip_seg_decode (
  input  wire logic [1:0] sel,  // captured selection code
  output logic      [7:0] mask  // lines carrying segment address
);
  always_comb begin
    case (sel)
      sip_pkg::sip_sel_none:    mask = 8'h00; // [R5]
      sip_pkg::sip_sel_2_lines: mask = 8'h03; // [R5]
      sip_pkg::sip_sel_4_lines: mask = 8'h0f; // [R5]
      sip_pkg::sip_sel_8_lines: mask = 8'hff; // [R5]
      default:                  mask = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// *** verif/sip_board.sv ***
// board model: pin levels seen by the segment port
`default_nettype none
module sip_board (
  input  wire logic [7:0] out,    // port drive value
  input  wire logic [7:0] oe,     // port drive enable
  input  wire logic [7:0] ext,    // level the board forces
  input  wire logic [7:0] ext_en, // board drive enable
  output logic      [7:0] pin     // resolved level
);
  timeunit 1ns;
  timeprecision 1ps;
  // port driver wins; an undriven line is held high by the pull-up, never left as x
  always_comb pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en);
endmodule
`default_nettype wire

// *** verif/sip_ports_asserts.sv ***
// assertion checker for the segment and input ports
`default_nettype none
module sip_ports_chk (
  input wire logic        pclk,               // clock
  input wire logic        presetn,            // reset
  input wire logic        psel,               // select
  input wire logic        penable,            // access
  input wire logic        pwrite,             // direction
  input wire logic [31:0] paddr,              // address
  input wire logic [31:0] pwdata,             // write data
  input wire logic [31:0] prdata,             // read data
  input wire logic        pready,             // ready
  input wire logic [7:0]  seg_pin_out,        // pin values
  input wire logic [7:0]  seg_pin_oe,         // pin enables
  input wire logic [7:0]  segment_address,    // a16..a23
  input wire logic        can_first_receive,  // rx one
  input wire logic        can_second_receive, // rx two
  input wire logic [15:0] input_pin,          // input pins
  input wire logic [15:0] analog_channel,     // taps
  input wire logic        timer6_dir_input,   // timer 6 up/down tap
  input wire logic        timer5_dir_input,   // timer 5 up/down tap
  input wire logic        timer6_count_input, // timer 6 count tap
  input wire logic        timer5_count_input, // timer 5 count tap
  input wire logic        timer4_dir_input,   // timer 4 up/down tap
  input wire logic        timer2_dir_input    // timer 2 up/down tap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_cnt; // edges since reset, saturating
  logic       cfg_ok; // selection code seen on a read
  logic [1:0] cfg;    // selection code read back
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic acc(input logic [17:0] a);
    return pready && paddr == {14'h0, a};
  endfunction
  ////////////////////////////////////////
  // keep $past from looking back into reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end
  // the code is only known here once software has read it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ok <= 1'b0;
      cfg <= 2'h0;
    end else if (acc(sip_pkg::addr_reset_config_high) && !pwrite) begin
      cfg_ok <= 1'b1;
      cfg <= prdata[1:0];
    end
  end
  ////////////////////////////////////////
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_dir_s;
    setup_s ##0 (pwrite && paddr == {14'h0, sip_pkg::addr_seg_port_direction});
  endsequence
  a_ready_setup: assert property (setup_s |=> pready)
    else $error("no ready one cycle after setup");
  a_upper_zero: assert property (acc(sip_pkg::addr_seg_port_data) && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("data register upper byte not zero");
  a_od_unimpl: assert property (acc(sip_pkg::addr_seg_port_open_drain) && !pwrite |-> (prdata & ~32'hc0) == 32'h0)
    else $error("unimplemented open drain bit set");
  a_analog_tap: assert property (up_cnt != 2'h0 |-> analog_channel == $past(input_pin))
    else $error("analog tap not the raw pin");
  a_timer_map: assert property (up_cnt == 2'h3 |-> {timer2_dir_input, timer4_dir_input, timer5_count_input,
    timer6_count_input, timer5_dir_input, timer6_dir_input} == $past(input_pin[15:10], 3))
    else $error("timer inputs wrong order");
  a_dir_drives: assert property (wr_dir_s |=> ##1 (seg_pin_oe[5:0] & $past(pwdata[5:0], 2)) == $past(pwdata[5:0], 2))
    else $error("direction bit set but line not driven");
  a_rx_on_seg: assert property (cfg_ok && cfg == sip_pkg::sip_sel_8_lines |-> can_first_receive && can_second_receive)
    else $error("receive not idle on segment line");
  a_seg_drive: assert property (cfg_ok && cfg == sip_pkg::sip_sel_8_lines |-> seg_pin_oe == 8'hff)
    else $error("segment lines not driven");
  a_seg_addr_out: assert property (cfg_ok && cfg == sip_pkg::sip_sel_8_lines |-> seg_pin_out == $past(segment_address))
    else $error("segment address not on pins");
endmodule
bind sip_ports sip_ports_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .seg_pin_out(seg_pin_out),
  .seg_pin_oe(seg_pin_oe), .segment_address(segment_address), .can_first_receive(can_first_receive),
  .can_second_receive(can_second_receive), .input_pin(input_pin), .analog_channel(analog_channel),
  .timer6_dir_input(timer6_dir_input), .timer5_dir_input(timer5_dir_input), .timer6_count_input(timer6_count_input),
  .timer5_count_input(timer5_count_input), .timer4_dir_input(timer4_dir_input), .timer2_dir_input(timer2_dir_input));
`default_nettype wire

// *** verif/test_segment_and_input_ports.sv ***
// random and corner-case bench for the segment and input ports
`default_nettype none
module test_segment_and_input_ports;
  timeunit 1ns;
  timeprecision 1ps;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, er, rx1, rx2, tx1, tx2;
  logic     [31:0] paddr, pwdata, prdata, rd, r;
  logic     [15:0] straps, in_pin, an;
  logic     [7:0]  pin, out, oe, seg_a, ext, ext_en, dv, dt, od, m;
  wire logic [5:0] tmr;
  int              miscompares, n_checks, seed;
  sip_ports i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_data_bus_pins(straps), .seg_pin_in(pin), .seg_pin_out(out), .seg_pin_oe(oe),
    .segment_address(seg_a), .can_first_transmit(tx1), .can_second_transmit(tx2),
    .can_first_receive(rx1), .can_second_receive(rx2), .input_pin(in_pin), .analog_channel(an),
    .timer6_dir_input(tmr[0]), .timer5_dir_input(tmr[1]), .timer6_count_input(tmr[2]),
    .timer5_count_input(tmr[3]), .timer4_dir_input(tmr[4]), .timer2_dir_input(tmr[5]));
  sip_board i_board (.out(out), .oe(oe), .ext(ext), .ext_en(ext_en), .pin(pin));
  ////////////////////////////////////////
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle cycle after it keeps psel from being assigned twice in a step
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until ready; a hung slave is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // straps must stand still through reset and the capture edges
  task automatic do_reset(input logic [1:0] c);
    @(posedge pclk);
    straps <= {3'h0, c, 11'h0} | (16'($random(seed)) & 16'he7ff);
    seg_a <= 8'($random(seed));
    ext_en <= 8'h00;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  function automatic logic [7:0] seg_mask(input logic [1:0] c);
    case (c)
      2'b01: return 8'h00;
      2'b11: return 8'h03;
      2'b00: return 8'h0f;
      default: return 8'hff;
    endcase
  endfunction
  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100us;
    miscompares++;
    end_sim();
  end
  initial begin
    seed = 32'h8764acbe;
    {pclk, psel, penable, pwrite, tx1, tx2, presetn} = 7'h00;
    {paddr, pwdata, straps, in_pin, seg_a, ext, ext_en} = 120'h0;
    miscompares = 0;
    n_checks = 0;
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(i));
      m = seg_mask(2'(i));
      // reset values and the captured code, segment lines up without software
      apb(1'b0, sip_pkg::addr_reset_config_high, 32'h0);
      chk(rd, 32'(i));
      apb(1'b0, sip_pkg::addr_seg_port_direction, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, sip_pkg::addr_seg_port_open_drain, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, sip_pkg::addr_seg_port_data, 32'h0);
      chk(rd, {24'h0, (m & seg_a) | ~m});
      chk(32'(oe), 32'(m));
      chk(32'(out & m), 32'(seg_a & m));
      // random general purpose traffic, open drain on the top lines
      repeat (8) begin
        dv = 8'($random(seed));
        dt = 8'($random(seed));
        r = $random(seed);
        od = r[7:0] & 8'hc0;
        ext <= 8'($random(seed));
        ext_en <= 8'($random(seed));
        apb(1'b1, sip_pkg::addr_seg_port_data, {r[31:8], dt});
        apb(1'b1, sip_pkg::addr_seg_port_direction, {24'h0, dv});
        apb(1'b1, sip_pkg::addr_seg_port_open_drain, r);
        apb(1'b0, sip_pkg::addr_seg_port_open_drain, 32'h0);
        chk(rd, {24'h0, od});
        apb(1'b0, sip_pkg::addr_seg_port_data, 32'h0);
        chk(rd, {24'h0, (dv & dt) | (~dv & ((m & seg_a) | (~m & (~ext_en | ext))))});
        chk(32'(oe), 32'(m | (dv & ~(od & dt))));
        chk(32'(out & ~m), 32'(dt & ~m));
      end
      // CAN on lines 4 to 7, then the input-only port and its taps
      apb(1'b1, sip_pkg::addr_extra_periph_ctrl, 32'h3);
      apb(1'b1, sip_pkg::addr_seg_port_direction, 32'hc0);
      apb(1'b1, sip_pkg::addr_seg_port_open_drain, 32'h0);
      ext_en <= 8'h30;
      {tx2, tx1} <= 2'($random(seed));
      in_pin <= 16'($random(seed));
      repeat (4) @(posedge pclk);
      chk(32'(out[7:6]), 32'((m[7:6] & seg_a[7:6]) | (~m[7:6] & {tx2, tx1})));
      chk(32'({rx2, rx1}), 32'({m[4] | ext[4], m[5] | ext[5]}));
      chk(32'(an), 32'(in_pin));
      chk(32'(tmr), 32'(in_pin[15:10]));
      apb(1'b1, sip_pkg::addr_input_port_data, r);
      chk(32'(er), 32'h0000_0000);
      apb(1'b0, sip_pkg::addr_input_port_data, 32'h0);
      chk(rd, {16'h0, in_pin});
      apb(1'b0, 18'h00010, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
    end
    end_sim();
  end
endmodule
`default_nettype wire
